// ---- bench/baseband_iq_input_port_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module baseband_iq_input_port_bench
  import bbi_pkg::*;
;
  localparam int NC = 3;
  logic clk = 0, rst = 1, in_valid = 0, bypass_mode = 0, pair_ready = 0, peak_ready = 0, stall = 0;
  logic [BBI_WORD_W-1:0] in_i = '0, in_q = '0, pair_i, pair_q, peak_word;
  logic [BBI_CHAN_W-1:0] in_chan, pair_chan;
  logic in_ready, pair_valid, peak_valid, peak_word_is_q, chan_overrun;
  int err_total = 0, cmp_count = 0, seed = 40930;
  logic [39:0] exp_q[$];
  always #2.5 clk = ~clk;
  bbi_link_if link();
  bbi_source #(.NUM_CHAN(NC)) bbi_source_inst(.clk(clk), .rst(rst), .link(link), .in_i(in_i),
    .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan));
  bbi_port #(.NUM_CHAN(NC)) bbi_port_inst(.clk(clk), .rst(rst), .link(link), .bypass_mode(bypass_mode),
    .pair_i(pair_i), .pair_q(pair_q), .pair_chan(pair_chan), .pair_valid(pair_valid),
    .pair_ready(pair_ready), .peak_word(peak_word), .peak_word_is_q(peak_word_is_q),
    .peak_valid(peak_valid), .peak_ready(peak_ready), .chan_overrun(chan_overrun));
  bbi_link_monitor #(.NUM_CHAN(NC)) bbi_link_monitor_inst(.clk(clk), .rst(rst),
    .sample_word_upper_bus(link.sample_word_upper_bus), .sample_low_bit_pins(link.sample_low_bit_pins),
    .interleave_frame_marker(link.interleave_frame_marker), .word_valid(link.word_valid),
    .word_ready(link.word_ready));
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // back-to-back random pairs, noting the expected outputs
  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      in_i = 18'($random(seed));
      in_q = 18'($random(seed));
      in_valid = 1;
      // ready moves only at rising edges, so its falling-edge value is the one sampled
      while (!in_ready) @(negedge clk);
      chk("in_chan", 40'(in_chan), 40'(k % NC));
      @(posedge clk);
      if (bypass_mode) begin
        exp_q.push_back({1'b0, in_i});
        exp_q.push_back({1'b1, in_q});
      end else exp_q.push_back({4'(k % NC), in_i, in_q});
    end
    @(negedge clk);
    in_valid = 0;
  endtask
  // receiver stalls at random, or fully while stall is set
  always @(negedge clk) begin
    pair_ready <= !stall && ($random(seed) & 3) != 0;
    peak_ready <= !stall && ($random(seed) & 3) != 0;
  end
  // compare each result against the oldest note
  always @(posedge clk) begin
    if (pair_valid && pair_ready) chk("pair", {pair_chan, pair_i, pair_q}, exp_q.pop_front());
    if (peak_valid && peak_ready) chk("peak", {peak_word_is_q, peak_word}, exp_q.pop_front());
  end
  // normal mode with buffer filled to refusal, then bypass
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) rst = 0;
    stall = 1;
    fork
      send(4 * NC);
      begin
        repeat (20) @(negedge clk);
        stall = 0;
      end
    join
    repeat (60) @(negedge clk);
    chk("drained", 40'(exp_q.size()), 40'h0);
    chk("overrun", 40'(chan_overrun), 40'h0);
    $display("normal test done");
    bypass_mode = 1;
    send(2 * NC);
    repeat (60) @(negedge clk);
    chk("drained", 40'(exp_q.size()), 40'h0);
    $display("bypass test done");
    report_and_stop();
  end
  // watchdog well beyond the expected run
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- bench/bbi_link_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module bbi_link_monitor
  import bbi_pkg::*;
#(
  parameter int NUM_CHAN = BBI_MAX_CHAN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [BBI_UPPER_W-1:0] sample_word_upper_bus,
  input wire logic [BBI_LOW_W-1:0] sample_low_bit_pins,
  input wire logic interleave_frame_marker,
  input wire logic word_valid,
  input wire logic word_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] pos_q;
  wire logic take = word_valid && word_ready;
  // word position inside one interleave sequence
  always_ff @(posedge clk) begin
    if (rst) pos_q <= 8'h00;
    else if (take) pos_q <= (pos_q == 8'(2*NUM_CHAN-1)) ? 8'h00 : pos_q + 8'h01;
  end
  sequence s_stall;
    word_valid && !word_ready;
  endsequence
  sequence s_held;
    word_valid && $stable({sample_word_upper_bus, sample_low_bit_pins, interleave_frame_marker});
  endsequence
  word_hold_a: assert property (s_stall |=> s_held)
    else $error("link word changed while refused");
  marker_place_a: assert property (take |-> interleave_frame_marker == (pos_q == 8'h00))
    else $error("frame marker misplaced");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !word_valid)
    else $error("link valid after reset");
  sequence s_i_taken;
    take && !pos_q[0];
  endsequence
  sequence s_q_offered;
    word_valid && !interleave_frame_marker;
  endsequence
  q_follows_a: assert property (s_i_taken |=> s_q_offered)
    else $error("Q word did not follow its I word");
  marker_valid_a: assert property (interleave_frame_marker |-> word_valid)
    else $error("frame marker without a word");
  reset_ready_a: assert property (disable iff (1'b0) rst |=> word_ready)
    else $error("port refuses words after reset");
endmodule
`default_nettype wire

// ---- verilog/bbi_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface bbi_link_if;
  import bbi_pkg::*;
  logic [BBI_UPPER_W-1:0] sample_word_upper_bus;
  logic [BBI_LOW_W-1:0] sample_low_bit_pins;
  logic interleave_frame_marker;
  logic word_valid;
  logic word_ready;

  modport src (
    output sample_word_upper_bus,
    output sample_low_bit_pins,
    output interleave_frame_marker,
    output word_valid,
    input word_ready
  );
  modport port (
    input sample_word_upper_bus,
    input sample_low_bit_pins,
    input interleave_frame_marker,
    input word_valid,
    output word_ready
  );
endinterface
`default_nettype wire

// ---- verilog/bbi_pkg.sv ----
package bbi_pkg;
  // word layout
  localparam int BBI_WORD_W = 18;
  localparam int BBI_UPPER_W = 16;
  localparam int BBI_LOW_W = 2;
  // channel count limit
  localparam int BBI_MAX_CHAN = 12;
  localparam int BBI_CHAN_W = 4;
  // clock limits, in MHz
  localparam int BBI_NORMAL_CLK_MHZ = 93;
  localparam int BBI_BYPASS_CLK_MHZ = 140;
  localparam int BBI_BYPASS_CPLX_MHZ = 70;
  // reset value and buffer depth
  localparam logic [BBI_CHAN_W-1:0] BBI_CHAN_RST = 4'h0;
  localparam int BBI_BUF_DEPTH = 2;

  typedef enum logic [0:0] {
    BBI_PH_I = 1'b0,
    BBI_PH_Q = 1'b1
  } bbi_phase_t;
endpackage

// ---- verilog/bbi_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module bbi_port
  import bbi_pkg::*;
#(
  parameter int NUM_CHAN = BBI_MAX_CHAN
) (
  input wire logic clk,
  input wire logic rst,
  bbi_link_if.port link,
  input wire logic bypass_mode,
  output logic [BBI_WORD_W-1:0] pair_i,
  output logic [BBI_WORD_W-1:0] pair_q,
  output logic [BBI_CHAN_W-1:0] pair_chan,
  output logic pair_valid,
  input wire logic pair_ready,
  output logic [BBI_WORD_W-1:0] peak_word,
  output logic peak_word_is_q,
  output logic peak_valid,
  input wire logic peak_ready,
  output logic chan_overrun
);
  // two-entry buffer of received words
  logic [BBI_WORD_W-1:0] buf_w_q [BBI_BUF_DEPTH];
  logic buf_m_q [BBI_BUF_DEPTH];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic rdy_q;
  logic rd_q;
  logic rd_d;
  logic wr_q;
  logic wr_d;
  logic [BBI_WORD_W-1:0] in_word;
  logic [BBI_WORD_W-1:0] head_w;
  logic head_m;
  logic push;
  logic pop;
  logic buf_empty;

  // demux state
  logic [BBI_CHAN_W-1:0] chan_q;
  logic [BBI_CHAN_W-1:0] chan_n;
  logic [BBI_CHAN_W-1:0] chan_d;
  logic [BBI_CHAN_W-1:0] last_chan;
  bbi_phase_t ph_q;
  bbi_phase_t ph_d;
  logic [BBI_WORD_W-1:0] i_q;
  logic is_q_word;

  // output slots of both paths
  logic [BBI_WORD_W-1:0] pi_q;
  logic [BBI_WORD_W-1:0] pq_q;
  logic [BBI_CHAN_W-1:0] pc_q;
  logic pv_q;
  logic pv_d;
  logic [BBI_WORD_W-1:0] pk_q;
  logic kq_q;
  logic kv_q;
  logic kv_d;
  logic out_free;
  logic pair_load;
  logic peak_load;

  // sticky alignment flag
  logic ov_q;
  logic marker_miss;

  // next channel in the cyclic order, wrapping after the last one
  function automatic logic [BBI_CHAN_W-1:0] wrap_chan(input logic [BBI_CHAN_W-1:0] c,
    input logic [BBI_CHAN_W-1:0] last);
    return (c == last) ? BBI_CHAN_RST : c + 4'h1;
  endfunction

  // word assembly and buffer status
  assign in_word = {link.sample_word_upper_bus, link.sample_low_bit_pins};
  assign buf_empty = (cnt_q == 2'h0);
  assign head_w = buf_w_q[rd_q];
  assign head_m = buf_m_q[rd_q];

  // ready comes from a flop, so the link sees no path through the port
  assign link.word_ready = rdy_q;
  assign push = link.word_valid && rdy_q;
  assign pop = !buf_empty && out_free;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign wr_d = push ? !wr_q : wr_q;
  assign rd_d = pop ? !rd_q : rd_q;

  // output slot of the active path is free
  assign out_free = bypass_mode ? (!kv_q || peak_ready) : (!pv_q || pair_ready);

  // marker forces an I word of channel 0
  assign is_q_word = !head_m && (ph_q == BBI_PH_Q);
  assign chan_n = head_m ? BBI_CHAN_RST : chan_q;
  assign ph_d = is_q_word ? BBI_PH_I : BBI_PH_Q;

  // channel that follows a completed pair
  assign last_chan = BBI_CHAN_W'(NUM_CHAN - 1);
  assign chan_d = wrap_chan(chan_n, last_chan);

  // a Q word closes a pair in normal mode, any word goes out in bypass
  assign pair_load = pop && !bypass_mode && is_q_word;
  assign peak_load = pop && bypass_mode;

  // a slot stays full until its receiver takes it
  assign pv_d = pair_load || (pv_q && !pair_ready);
  assign kv_d = peak_load || (kv_q && !peak_ready);

  // an unmarked I word on channel 0 means the sender lost alignment
  assign marker_miss = pop && !head_m && !is_q_word && (chan_q == BBI_CHAN_RST)
    && !bypass_mode && (NUM_CHAN > 1);

  // buffer pointers and ready
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      rdy_q <= (cnt_d != 2'h2); // two words held refuse the next
    end
  end

  // buffer data, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      buf_w_q[wr_q] <= in_word;
      buf_m_q[wr_q] <= link.interleave_frame_marker;
    end
  end

  // phase and channel tracking, realigned by marker
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q <= BBI_PH_I;
      chan_q <= BBI_CHAN_RST;
      i_q <= '0;
    end else if (pop) begin
      ph_q <= ph_d;
      if (is_q_word) begin
        chan_q <= chan_d;
      end else begin
        chan_q <= chan_n;
        i_q <= head_w;
      end
    end
  end

  // normal path: complete pairs to the channel upconverters
  always_ff @(posedge clk) begin
    if (rst) begin
      pv_q <= 1'b0;
      pi_q <= '0;
      pq_q <= '0;
      pc_q <= BBI_CHAN_RST;
    end else begin
      pv_q <= pv_d;
      if (pair_load) begin
        pi_q <= i_q;
        pq_q <= head_w;
        pc_q <= chan_q;
      end
    end
  end

  // bypass path: interleaved words to peak reduction stage
  always_ff @(posedge clk) begin
    if (rst) begin
      kv_q <= 1'b0;
      pk_q <= '0;
      kq_q <= 1'b0;
    end else begin
      kv_q <= kv_d;
      if (peak_load) begin
        pk_q <= head_w;
        kq_q <= is_q_word;
      end
    end
  end

  // sticky flag, only reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_q <= 1'b0;
    end else if (marker_miss) begin
      ov_q <= 1'b1;
    end
  end

  // outputs straight from the slot registers and the sticky flag
  assign pair_i = pi_q;
  assign pair_q = pq_q;
  assign pair_chan = pc_q;
  assign pair_valid = pv_q;
  assign peak_word = pk_q;
  assign peak_word_is_q = kq_q;
  assign peak_valid = kv_q;
  assign chan_overrun = ov_q;
endmodule
`default_nettype wire

// ---- verilog/bbi_source.sv ----
`timescale 1ns/10ps
`default_nettype none
// baseband processor end: sends I then Q words of each channel in turn
module bbi_source
  import bbi_pkg::*;
#(
  parameter int NUM_CHAN = BBI_MAX_CHAN
) (
  input wire logic clk,
  input wire logic rst,
  bbi_link_if.src link,
  input wire logic [BBI_WORD_W-1:0] in_i,
  input wire logic [BBI_WORD_W-1:0] in_q,
  input wire logic in_valid,
  output logic in_ready,
  output logic [BBI_CHAN_W-1:0] in_chan
);
  logic [BBI_UPPER_W-1:0] up_q;
  logic [BBI_LOW_W-1:0] low_q;
  logic mark_q, vld_q, ph_q;
  logic [BBI_WORD_W-1:0] hold_q_q;
  logic [BBI_CHAN_W-1:0] chan_q;
  logic [BBI_CHAN_W-1:0] last_chan;
  logic advance, take_pair, send_q;

  assign last_chan = BBI_CHAN_W'(NUM_CHAN - 1);
  // word on the link moves when taken or when the slot is empty
  assign advance = !vld_q || link.word_ready;
  assign take_pair = advance && !ph_q && in_valid;
  assign send_q = advance && ph_q;
  assign in_ready = advance && !ph_q;
  assign in_chan = chan_q;

  // 18-bit word split onto upper bus and low pins
  assign link.sample_word_upper_bus = up_q;
  assign link.sample_low_bit_pins = low_q;
  assign link.interleave_frame_marker = mark_q;
  assign link.word_valid = vld_q;

  // interleave I then Q, marker on I of channel 0
  always_ff @(posedge clk) begin
    if (rst) begin
      up_q <= '0;
      low_q <= '0;
      mark_q <= 1'b0;
      vld_q <= 1'b0;
      ph_q <= 1'b0;
      hold_q_q <= '0;
      chan_q <= BBI_CHAN_RST;
    end else if (send_q) begin
      {up_q, low_q} <= hold_q_q;
      mark_q <= 1'b0;
      vld_q <= 1'b1;
      ph_q <= 1'b0;
      chan_q <= (chan_q == last_chan) ? BBI_CHAN_RST : chan_q + 4'h1;
    end else if (take_pair) begin
      {up_q, low_q} <= in_i;
      hold_q_q <= in_q;
      mark_q <= (chan_q == BBI_CHAN_RST);
      vld_q <= 1'b1;
      ph_q <= 1'b1;
    end else if (advance) begin
      vld_q <= 1'b0;
      mark_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire
